// ---- hdl/ppb_pkg.sv ----
// Shared types and constants for the page blocking unit.
package ppb_pkg;

  // ----------------------------------------------------------------
  // Request selection
  // ----------------------------------------------------------------
  localparam logic [31:0] LEAF_PAGE_BLOCK = 32'h0000_0009;
  localparam logic [1:0] PRIV_LEVEL_OK = 2'h0;
  localparam int PAGE_OFS_W = 12;
  localparam int VA_TOP = 47;

  // ----------------------------------------------------------------
  // Busy-operation vector bit positions
  // ----------------------------------------------------------------
  localparam int OP_ADD = 0;
  localparam int OP_AUGMENT = 1;
  localparam int OP_CREATE = 2;
  localparam int OP_LOAD = 3;
  localparam int OP_TYPE_MOD = 4;
  localparam int OP_WRITE_BACK = 5;
  localparam int OP_ACCEPT = 6;
  localparam int OP_ACCEPT_COPY = 7;
  localparam int OP_PERM_EXT = 8;
  localparam int OP_PERM_RESTR = 9;
  localparam int OP_EXTEND = 10;
  localparam int OP_INIT = 11;
  localparam int OP_EPOCH = 12;
  localparam int OP_W = 13;
  // Only operations that write the page collide with a shared access.
  localparam logic [OP_W-1:0] WRITER_MASK = 13'h003F;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CLEAR = 8'h04;
  localparam logic [7:0] REG_ENABLE = 8'h08;
  localparam logic [7:0] REG_CACHE_BASE = 8'h0C;
  localparam logic [7:0] REG_MAP_INDEX = 8'h10;
  localparam logic [7:0] REG_MAP_DATA = 8'h14;
  localparam logic [7:0] REG_BLOCK_COUNT = 8'h18;
  localparam int EV_DONE = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_BLOCKED = 2;
  localparam int EV_W = 3;
  localparam int MAP_VALID_BIT = 0;
  localparam int MAP_BLOCKED_BIT = 1;
  localparam int MAP_TYPE_LSB = 2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    type_regular, type_thread_control, type_control_page, type_trim,
    type_shadow_first, type_shadow_rest, type_version, type_other
  } ppb_ptype_t;

  typedef enum logic [1:0] {FLT_NONE, FLT_PROTECTION, FLT_PAGE} ppb_fault_t;

  typedef struct packed {
    logic valid;
    logic blocked;
    ppb_ptype_t ptype;
  } ppb_entry_t;

  typedef struct packed {
    logic [31:0] leaf;
    logic [1:0] priv;
    logic mode64;
    logic [63:0] eff_addr;
    logic [63:0] seg_base;
    logic [31:0] seg_limit;
  } ppb_req_t;

  typedef struct packed {
    ppb_fault_t fault;
    logic [63:0] fault_code;
    logic [63:0] status;
    logic zero_flag;
    logic carry_flag;
    logic parity_flag;
    logic adjust_flag;
    logic overflow_flag;
    logic sign_flag;
  } ppb_rsp_t;

endpackage : ppb_pkg

// ---- hdl/ppb_addr_check.sv ----
// Address forming and range checks for the page blocking unit.
`timescale 1ns/1ps
module ppb_addr_check
  import ppb_pkg::*;
#(
  parameter int NUM_PAGES = 16,
  parameter int IDX_W = 4
) (
  input wire ppb_req_t req_in,
  input wire logic [31:0] cache_base_in,
  output logic canon_bad_out,
  output logic limit_bad_out,
  output logic align_bad_out,
  output logic outside_out,
  output logic [63:0] lin_out,
  output logic [IDX_W-1:0] idx_out
);

  logic [63:0] lin;
  logic [63:0] diff;

  // ----------------------------------------------------------------
  // Linear address always comes from the data segment; no override.
  // ----------------------------------------------------------------
  always_comb begin
    if (req_in.mode64) begin
      lin = req_in.eff_addr + req_in.seg_base;
    end else begin
      lin = {32'h0000_0000, req_in.eff_addr[31:0] + req_in.seg_base[31:0]};
    end
    canon_bad_out = req_in.mode64 && !((&lin[63:VA_TOP]) || !(|lin[63:VA_TOP]));
    limit_bad_out = !req_in.mode64 && (req_in.eff_addr[31:0] > req_in.seg_limit);
    align_bad_out = |lin[PAGE_OFS_W-1:0];
    diff = {12'h000, lin[63:PAGE_OFS_W]} - {32'h0000_0000, cache_base_in};
    // A page below the base wraps to a huge difference and fails too.
    outside_out = diff >= 64'(NUM_PAGES);
    idx_out = diff[IDX_W-1:0];
    lin_out = lin;
  end

endmodule : ppb_addr_check

// ---- hdl/ppb_block_unit.sv ----
// Top of the page blocking unit: checks, page map, status registers.
// ----------------------------------------------------------------
// What this block does
// - A target address off a 4 KByte boundary ends in a protection fault with code zero.
// - A target outside the page cache ends in a page fault carrying that address, map untouched.
// - Once the address checks pass, all six flags and the status result start at zero.
// - A page in conflicting use sets the zero flag and returns the page conflict code.
// - An invalid map entry sets the zero flag and returns the page invalid code, entry untouched.
// - An unblockable page type sets carry and returns the control page or not blockable code.
// - A page already blocked sets carry, returns the already blocked code and stays as is.
// - Otherwise the blocked attribute is written to one with zero status and both flags clear, unless software writes the map data register in the same cycle.
// - An epoch lock on the owning control page returns the epoch locked code; the requester retries.
// - Access is shared; only operations writing the page give the conflict code, never a fault.
// - Accept, permission, extend, initialize and epoch operations run beside it freely.
// - In 64-bit mode a non-canonical target gives a protection fault with code zero.
// - In protected mode an address above the segment limit gives a protection fault with code zero.
// - Only leaf 09H at privilege level 0 is accepted; others give a protection fault.
// - The linear address is data segment base plus effective address, with no override.
// ----------------------------------------------------------------
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module ppb_block_unit
  import ppb_pkg::*;
#(
  parameter int NUM_PAGES = 16,
  parameter int IDX_W = 4,
  parameter logic [63:0] CODE_ALREADY_BLOCKED = 64'h0000_0000_0000_0001,
  parameter logic [63:0] CODE_EPOCH_LOCKED = 64'h0000_0000_0000_0002,
  parameter logic [63:0] CODE_NOT_BLOCKABLE = 64'h0000_0000_0000_0003,
  parameter logic [63:0] CODE_PAGE_INVALID = 64'h0000_0000_0000_0004,
  parameter logic [63:0] CODE_PAGE_CONFLICT = 64'h0000_0000_0000_0005,
  parameter logic [63:0] CODE_IS_CONTROL = 64'h0000_0000_0000_0006
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic req_valid_in,
  input wire ppb_req_t req_in,
  input wire logic [OP_W-1:0] busy_ops_in,
  input wire logic epoch_lock_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic rsp_valid_out,
  output ppb_rsp_t rsp_out,
  output logic [31:0] reg_rdata_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // Address checks
  // ----------------------------------------------------------------
  logic canon_bad;
  logic limit_bad;
  logic align_bad;
  logic outside;
  logic [63:0] lin;
  logic [IDX_W-1:0] idx;
  logic [31:0] base_q, base_d;

  ppb_addr_check #(
    .NUM_PAGES(NUM_PAGES),
    .IDX_W(IDX_W)
  ) u_check (
    .req_in(req_in),
    .cache_base_in(base_q),
    .canon_bad_out(canon_bad),
    .limit_bad_out(limit_bad),
    .align_bad_out(align_bad),
    .outside_out(outside),
    .lin_out(lin),
    .idx_out(idx)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ppb_entry_t map_q [NUM_PAGES];
  ppb_entry_t entry;
  ppb_rsp_t rsp_d;
  logic rsp_valid_d;
  logic blk_we;
  logic sw_map_we;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] sts_q, sts_d;
  logic [EV_W-1:0] en_q, en_d;
  logic [IDX_W-1:0] midx_q, midx_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] rdata_d;
  logic irq_d;
  logic bad_sel;
  logic conflict;

  // Only writers of the page collide; accept, extend, epoch and the rest pass.
  assign conflict = |(busy_ops_in & WRITER_MASK);
  assign entry = map_q[idx];
  assign bad_sel = (req_in.leaf != LEAF_PAGE_BLOCK) || (req_in.priv != PRIV_LEVEL_OK);

  // ----------------------------------------------------------------
  // Operation decision
  // ----------------------------------------------------------------
  // Faults leave all flags at zero in the response; the flags only carry
  // meaning when the fault field reads none.
  always_comb begin
    rsp_d = '0;
    rsp_valid_d = req_valid_in;
    blk_we = 1'b0;
    if (req_valid_in) begin
      if (bad_sel) begin
        rsp_d.fault = FLT_PROTECTION;
      end else if (canon_bad || limit_bad) begin
        rsp_d.fault = FLT_PROTECTION;
      end else if (align_bad) begin
        rsp_d.fault = FLT_PROTECTION;
      end else if (outside) begin
        rsp_d.fault = FLT_PAGE;
        rsp_d.fault_code = lin;
      end else if (conflict) begin
        rsp_d.zero_flag = 1'b1;
        rsp_d.status = CODE_PAGE_CONFLICT;
      end else if (epoch_lock_in) begin
        rsp_d.status = CODE_EPOCH_LOCKED;
      end else if (!entry.valid) begin
        rsp_d.zero_flag = 1'b1;
        rsp_d.status = CODE_PAGE_INVALID;
      end else if (!(entry.ptype inside {type_regular, type_thread_control, type_trim,
                                         type_shadow_first, type_shadow_rest})) begin
        rsp_d.carry_flag = 1'b1;
        rsp_d.status = (entry.ptype == type_control_page) ? CODE_IS_CONTROL : CODE_NOT_BLOCKABLE;
      end else if (entry.blocked) begin
        rsp_d.carry_flag = 1'b1;
        rsp_d.status = CODE_ALREADY_BLOCKED;
      end else begin
        blk_we = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_out <= '0;
    end else begin
      rsp_valid_out <= rsp_valid_d;
      rsp_out <= rsp_d;
    end
  end

  // ----------------------------------------------------------------
  // Page map
  // ----------------------------------------------------------------
  // Software loads entries through the map data register. When software
  // and the unit write in the same cycle, software wins; the response
  // still reports the block, which is the price of a single write port.
  // Fields are placed by the register layout, not by the struct member order.
  assign sw_map_we = reg_wr_in && (reg_addr_in == REG_MAP_DATA);

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_PAGES; i++) begin
        map_q[i] <= '0;
      end
    end else if (sw_map_we) begin
      map_q[midx_q].valid <= reg_wdata_in[MAP_VALID_BIT];
      map_q[midx_q].blocked <= reg_wdata_in[MAP_BLOCKED_BIT];
      map_q[midx_q].ptype <= ppb_ptype_t'(reg_wdata_in[MAP_TYPE_LSB +: 3]);
    end else if (blk_we) begin
      map_q[idx].blocked <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register file and interrupt
  // ----------------------------------------------------------------
  // Events: every response, every fault, every successful block.
  always_comb begin
    ev = '0;
    ev[EV_DONE] = rsp_valid_d;
    ev[EV_FAULT] = rsp_valid_d && (rsp_d.fault != FLT_NONE);
    ev[EV_BLOCKED] = blk_we;
    en_d = en_q;
    base_d = base_q;
    midx_d = midx_q;
    cnt_d = cnt_q + {31'h0000_0000, blk_we};
    sts_d = sts_q;
    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_CLEAR: sts_d = sts_q & ~reg_wdata_in[EV_W-1:0];
        REG_ENABLE: en_d = reg_wdata_in[EV_W-1:0];
        REG_CACHE_BASE: base_d = reg_wdata_in;
        REG_MAP_INDEX: midx_d = reg_wdata_in[IDX_W-1:0];
        default: ;
      endcase
    end
    // A new event beats a clear arriving in the same cycle.
    sts_d = sts_d | ev;
    rdata_d = RESET_WORD;
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_STATUS: rdata_d = {29'h0000_0000, sts_q};
        REG_ENABLE: rdata_d = {29'h0000_0000, en_q};
        REG_CACHE_BASE: rdata_d = base_q;
        REG_MAP_INDEX: rdata_d = 32'(midx_q);
        REG_MAP_DATA: rdata_d = {27'h000_0000, map_q[midx_q].ptype, map_q[midx_q].blocked, map_q[midx_q].valid};
        REG_BLOCK_COUNT: rdata_d = cnt_q;
        default: rdata_d = RESET_WORD;
      endcase
    end
    irq_d = |(sts_d & en_d);
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sts_q <= '0;
      en_q <= '0;
      base_q <= RESET_WORD;
      midx_q <= '0;
      cnt_q <= RESET_WORD;
      reg_rdata_out <= RESET_WORD;
      irq_out <= 1'b0;
    end else begin
      sts_q <= sts_d;
      en_q <= en_d;
      base_q <= base_d;
      midx_q <= midx_d;
      cnt_q <= cnt_d;
      reg_rdata_out <= rdata_d;
      irq_out <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  // Each check looks one cycle after the request, where the answer stands; chk_priv_fault also checks the cycle after that.
  // Address checks pass when selection, canonical form and limit all pass.
  logic addr_ok;
  assign addr_ok = !bad_sel && !canon_bad && !limit_bad;

  chk_addr_fault: assert property (
    req_valid_in && !bad_sel && (canon_bad || limit_bad)
    |=> rsp_valid_out && rsp_out.fault == FLT_PROTECTION && rsp_out.fault_code == 64'h0
  ) else $error("bad form or limit did not give a zero-code protection fault");

  chk_epoch_code: assert property (
    req_valid_in && addr_ok && !align_bad && !outside && !conflict && epoch_lock_in
    |=> rsp_out.status == CODE_EPOCH_LOCKED && !rsp_out.zero_flag && !rsp_out.carry_flag
  ) else $error("epoch lock did not return the epoch locked code");

  chk_writer_only: assert property (
    req_valid_in && addr_ok && !align_bad && !outside && (busy_ops_in & WRITER_MASK) == '0
    |=> rsp_out.status != CODE_PAGE_CONFLICT
  ) else $error("a tolerated operation gave the conflict code");

  chk_align_fault: assert property (
    req_valid_in && addr_ok && align_bad |=> rsp_out.fault == FLT_PROTECTION && rsp_out.fault_code == 64'h0
  ) else $error("misaligned target did not give a zero-code protection fault");

  chk_outside_pf: assert property (
    req_valid_in && addr_ok && !align_bad && outside
    |=> rsp_out.fault == FLT_PAGE && rsp_out.fault_code == $past(lin) && cnt_q == $past(cnt_q)
  ) else $error("outside target did not give a page fault with its address");

  chk_flags_clear: assert property (
    rsp_valid_out && rsp_out.fault == FLT_NONE
    |-> !(rsp_out.parity_flag || rsp_out.adjust_flag || rsp_out.overflow_flag || rsp_out.sign_flag)
  ) else $error("minor flags not cleared on a completed operation");

  chk_conflict_code: assert property (
    req_valid_in && addr_ok && !align_bad && !outside && conflict
    |=> rsp_out.zero_flag && !rsp_out.carry_flag && rsp_out.status == CODE_PAGE_CONFLICT
  ) else $error("conflicting use did not return the conflict code");

  chk_invalid_code: assert property (
    rsp_valid_out && rsp_out.status == CODE_PAGE_INVALID |-> rsp_out.zero_flag && $past(!entry.valid)
  ) else $error("page invalid code without an invalid entry");

  chk_type_code: assert property (
    rsp_valid_out && rsp_out.carry_flag && rsp_out.status != CODE_ALREADY_BLOCKED
    |-> $past(entry.ptype == type_control_page) == (rsp_out.status == CODE_IS_CONTROL)
  ) else $error("unblockable type returned the wrong code");

  chk_already_kept: assert property (
    rsp_valid_out && rsp_out.status == CODE_ALREADY_BLOCKED |-> rsp_out.carry_flag && $past(cnt_q) == cnt_q
  ) else $error("already blocked page was blocked again");

  chk_block_done: assert property (
    blk_we && !sw_map_we |=> map_q[$past(idx)].blocked && rsp_out.status == 64'h0
    && !rsp_out.zero_flag && !rsp_out.carry_flag && cnt_q == $past(cnt_q) + 32'h0000_0001
  ) else $error("successful block did not set the attribute");

  chk_priv_fault: assert property (
    req_valid_in && bad_sel |=> rsp_valid_out && rsp_out.fault == FLT_PROTECTION ##1 !rsp_valid_out || $past(req_valid_in)
  ) else $error("wrong leaf or level was not refused");

  chk_one_answer: assert property (
    rsp_valid_out == $past(req_valid_in)
  ) else $error("response count does not match requests");

endmodule : ppb_block_unit

// ---- verification/ppb_requester.sv ----
// Model of the execution pipeline that issues page blocking requests.
`timescale 1ns/1ps
module ppb_requester
  import ppb_pkg::*;
(
  input wire logic clk_in,
  output logic req_valid_out,
  output ppb_req_t req_out,
  input wire logic rsp_valid_in,
  input wire ppb_rsp_t rsp_in
);
  // ----------------------------------------------------------------
  // Request driver
  // ----------------------------------------------------------------
  // Idle at time zero so the unit sees no request during reset.
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
  end

  // One request, its answer in the next cycle, and the valid line one cycle later.
  task automatic issue(input ppb_req_t rq, output ppb_rsp_t rs, output logic [1:0] vld);
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_out <= rq;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    // A released request shows garbage, so the unit must not rely on stale fields.
    req_out <= ~rq;
    #1;
    rs = rsp_in;
    vld[1] = rsp_valid_in;
    @(posedge clk_in);
    #1;
    vld[0] = rsp_valid_in;
  endtask : issue
endmodule : ppb_requester

// ---- verification/ppb_block_unit_test.sv ----
// Self-checking testbench of the page blocking unit.
`timescale 1ns/1ps
module ppb_block_unit_test;
  import ppb_pkg::*;
  localparam logic [63:0] C_ALR = 64'h11;
  localparam logic [63:0] C_EPO = 64'h12;
  localparam logic [63:0] C_NB = 64'h13;
  localparam logic [63:0] C_INV = 64'h14;
  localparam logic [63:0] C_CON = 64'h15;
  localparam logic [63:0] C_CTL = 64'h16;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid;
  ppb_req_t req;
  logic [OP_W-1:0] busy = '0;
  logic epoch = 1'b0;
  logic [7:0] raddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rsp_valid;
  ppb_rsp_t rsp;
  logic [31:0] rdata;
  logic irq;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int i;
  logic [31:0] d;
  logic [63:0] ea;

  // ----------------------------------------------------------------
  // Clock, units and timeout
  // ----------------------------------------------------------------
  always #20 clk = ~clk;

  ppb_block_unit #(.CODE_ALREADY_BLOCKED(C_ALR), .CODE_EPOCH_LOCKED(C_EPO), .CODE_NOT_BLOCKABLE(C_NB),
    .CODE_PAGE_INVALID(C_INV), .CODE_PAGE_CONFLICT(C_CON), .CODE_IS_CONTROL(C_CTL)) dut_u (
    .ref_clk_in(clk), .nrst_in(nrst), .req_valid_in(req_valid), .req_in(req), .busy_ops_in(busy),
    .epoch_lock_in(epoch), .reg_addr_in(raddr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .rsp_valid_out(rsp_valid), .rsp_out(rsp), .reg_rdata_out(rdata), .irq_out(irq));

  ppb_requester req_u (.clk_in(clk), .req_valid_out(req_valid), .req_out(req),
    .rsp_valid_in(rsp_valid), .rsp_in(rsp));

  // The whole run needs well under a thousand cycles; a hang is cut off here.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    raddr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    raddr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_rd

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk_reg

  function automatic ppb_rsp_t mk(ppb_fault_t f, logic [63:0] c, logic [63:0] s, logic z, logic cf);
    mk = '0;
    mk.fault = f;
    mk.fault_code = c;
    mk.status = s;
    mk.zero_flag = z;
    mk.carry_flag = cf;
  endfunction : mk

  // Sends one request and compares the whole answer, other flags included, and its one-cycle valid.
  task automatic blk(input logic [63:0] a, input ppb_rsp_t e, input logic [31:0] lf = LEAF_PAGE_BLOCK,
    input logic [1:0] pv = PRIV_LEVEL_OK, input logic m = 1'b1, input logic [63:0] sb = 64'h0,
    input logic [31:0] lim = 32'hFFFF_FFFF);
    ppb_req_t q;
    ppb_rsp_t g;
    logic [1:0] v;
    q = '{leaf: lf, priv: pv, mode64: m, eff_addr: a, seg_base: sb, seg_limit: lim};
    req_u.issue(q, g, v);
    n_compared++;
    if (g !== e || v !== 2'b10) begin
      num_errors++;
      $display("[ERR] rsp exp %h got %h valid %b", e, g, v);
    end
  endtask : blk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    reg_wr(REG_CACHE_BASE, 32'h10);
    reg_wr(REG_ENABLE, 32'h7);
    blk(64'h10004, mk(FLT_PROTECTION, 0, 0, 0, 0));
    blk(64'h20000, mk(FLT_PAGE, 64'h20000, 0, 0, 0));
    blk(64'h10000, mk(FLT_PROTECTION, 0, 0, 0, 0), 32'h8);
    blk(64'h10000, mk(FLT_PROTECTION, 0, 0, 0, 0), LEAF_PAGE_BLOCK, 2'h3);
    blk(64'h0001_0000_0001_0000, mk(FLT_PROTECTION, 0, 0, 0, 0));
    blk(64'h10000, mk(FLT_PROTECTION, 0, 0, 0, 0), LEAF_PAGE_BLOCK, 2'h0, 1'b0, 0, 32'hFFFF);
    blk(64'h10000, mk(FLT_NONE, 0, C_INV, 1, 0), LEAF_PAGE_BLOCK, 2'h0, 1'b0, 0, 32'h10000);
    blk(64'h9000, mk(FLT_NONE, 0, C_INV, 1, 0), LEAF_PAGE_BLOCK, 2'h0, 1'b1, 64'h10000);
    // Every busy operation in turn; page 0 is invalid, so a tolerated one ends at validity.
    for (i = 0; i < OP_W; i++) begin
      @(posedge clk);
      busy <= 13'h0001 << i;
      blk(64'h10000, mk(FLT_NONE, 0, (i < 6) ? C_CON : C_INV, 1, 0));
    end
    @(posedge clk);
    busy <= '0;
    epoch <= 1'b1;
    blk(64'h10000, mk(FLT_NONE, 0, C_EPO, 0, 0));
    @(posedge clk);
    epoch <= 1'b0;
    blk(64'h10000, mk(FLT_NONE, 0, C_INV, 1, 0));
    // Each page type on its own page, blocked twice where blockable.
    for (i = 0; i < 8; i++) begin
      ea = 64'h10000 + (64'(i + 1) << 12);
      reg_wr(REG_MAP_INDEX, 32'(i + 1));
      reg_wr(REG_MAP_DATA, {27'h0, 3'(i), 2'b01});
      if (i == 2 || i > 5) begin
        blk(ea, mk(FLT_NONE, 0, (i == 2) ? C_CTL : C_NB, 0, 1));
        reg_rd(REG_MAP_DATA, d);
        chk_reg("map", {27'h0, 3'(i), 2'b01}, d);
      end else begin
        blk(ea, mk(FLT_NONE, 0, 0, 0, 0));
        blk(ea, mk(FLT_NONE, 0, C_ALR, 0, 1));
        reg_rd(REG_MAP_DATA, d);
        chk_reg("map", {27'h0, 3'(i), 2'b11}, d);
      end
    end
    // Interrupt: clear, raise on one block, mask, clear again.
    reg_wr(REG_CLEAR, 32'h7);
    reg_wr(REG_STATUS, 32'hFF);
    reg_rd(REG_STATUS, d);
    chk_reg("status", 32'h0, d);
    chk_reg("irq", 32'h0, {31'h0, irq});
    reg_wr(REG_MAP_INDEX, 32'hA);
    reg_wr(REG_MAP_DATA, 32'h1);
    blk(64'h1A000, mk(FLT_NONE, 0, 0, 0, 0));
    reg_rd(REG_STATUS, d);
    chk_reg("status", 32'h5, d);
    chk_reg("irq", 32'h1, {31'h0, irq});
    reg_wr(REG_ENABLE, 32'h2);
    reg_rd(REG_ENABLE, d);
    chk_reg("enable", 32'h2, d);
    chk_reg("irq", 32'h0, {31'h0, irq});
    reg_wr(REG_ENABLE, 32'h7);
    reg_wr(REG_CLEAR, 32'h7);
    reg_rd(REG_BLOCK_COUNT, d);
    chk_reg("count", 32'h6, d);
    chk_reg("irq", 32'h0, {31'h0, irq});
    reg_rd(8'h1C, d);
    chk_reg("unmapped", 32'h0, d);
    summarize();
  end
endmodule : ppb_block_unit_test
